/* File: fpc_counter.sv */
// fringe position counter core: sync, range select, 12-bit up/down counter, dac feed
//
// Summary of operation
// - one counter increment per accepted step pulse
// - step sign level selects up or down
// - counter is 12 bits, 4096 increments
// - zero pulse clears the counter
// - counter value continuously drives 12-bit dac
// - three selectable range extensions beyond direct
// - extensions divide steps by integer factor
// - direct increment is 316.4 nm
// - hi-res variants get multiplied pulses upstream
// - hi-res keeps 12-bit width, smaller span
// - lowest hi-res increment about 2 nm
// - base variant: one pulse per fringe
// - range applied by system control load strobe
`timescale 1ns/1ps
`default_nettype none
module fpc_counter
#(
	parameter logic [fpc_pkg::DIV_W-1:0] DIV_EXT1 = fpc_pkg::DIV_EXT1,
	parameter logic [fpc_pkg::DIV_W-1:0] DIV_EXT2 = fpc_pkg::DIV_EXT2,
	parameter logic [fpc_pkg::DIV_W-1:0] DIV_EXT3 = fpc_pkg::DIV_EXT3,
	parameter bit                        HIRES    = 1'b0
)
(
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	// demodulator pins
	input  wire logic                          step_pulse,
	input  wire logic                          step_up,
	input  wire logic                          zero_pulse,
	// system control
	input  wire logic [fpc_pkg::RANGE_W-1:0]   range_sel,
	input  wire logic                          range_load,
	output logic [fpc_pkg::RANGE_W-1:0]        range_active,
	output logic                               range_applied,
	output logic                               hires_variant,
	// converter
	output logic [fpc_pkg::CNT_W-1:0]          dac_code
);
	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers: two flops per pin, first stage read only by second
	localparam int unsigned N_PIN    = 3;
	localparam int unsigned PIN_STEP = 0;
	localparam int unsigned PIN_UP   = 1;
	localparam int unsigned PIN_ZERO = 2;

	wire  [N_PIN-1:0] pin_raw = {zero_pulse, step_up, step_pulse};
	wire  [N_PIN-1:0] pin_sync;

	for (genvar g = 0; g < N_PIN; g++)
	begin : g_sync
		logic s1_q;
		logic s2_q;

		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
			end
			else
			begin
				s1_q <= pin_raw[g];
				s2_q <= s1_q;
			end
		end

		assign pin_sync[g] = s2_q;
	end

	//////////////////////////////////////////////////////////////////////////
	// edge detection; both pins idle low, so no false edge after reset
	logic step_dly_q;
	logic step_prev_q;
	logic zero_prev_q;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			step_dly_q  <= 1'b0;
			step_prev_q <= 1'b0;
			zero_prev_q <= 1'b0;
		end
		else
		begin
			step_dly_q  <= pin_sync[PIN_STEP];
			step_prev_q <= step_dly_q;
			zero_prev_q <= pin_sync[PIN_ZERO];
		end
	end

	// step path one flop deeper than the sign, so the sign is taken a
	// cycle after the edge, well inside the window the demodulator holds it
	wire step_rise = step_dly_q && !step_prev_q;
	wire zero_rise = pin_sync[PIN_ZERO] && !zero_prev_q;
	wire step_sign = pin_sync[PIN_UP];

	//////////////////////////////////////////////////////////////////////////
	// range selection
	logic [fpc_pkg::RANGE_W-1:0] range_q;
	logic                        applied_q;

	// a load takes effect on the very next step; the divider residue is kept
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			range_q <= fpc_pkg::RANGE_RST;
		else if (range_load)
			range_q <= range_sel;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			applied_q <= 1'b0;
		else
			applied_q <= range_load;
	end

	fpc_pkg::fpc_range_t       range_e;
	logic [fpc_pkg::DIV_W-1:0] factor;

	assign range_e = fpc_pkg::fpc_range_t'(range_q);

	// the range only sets the divider; the count keeps its width in all

	always_comb
	begin
		case (range_e)
			fpc_pkg::FPC_RANGE_DIRECT: factor = fpc_pkg::DIV_DIRECT;
			fpc_pkg::FPC_RANGE_EXT1:   factor = DIV_EXT1;
			fpc_pkg::FPC_RANGE_EXT2:   factor = DIV_EXT2;
			fpc_pkg::FPC_RANGE_EXT3:   factor = DIV_EXT3;
			default:                   factor = fpc_pkg::DIV_DIRECT;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// prescaler
	fpc_step_if sp ();

	assign sp.raw_step = step_rise;
	assign sp.raw_up   = step_sign;
	assign sp.clear    = zero_rise;
	assign sp.factor   = factor;

	fpc_prescaler u_div
	(
		.clk    (clk),
		.arst_n (arst_n),
		.sp     (sp)
	);

	//////////////////////////////////////////////////////////////////////////
	// position counter; hi-res pulses arrive pre-multiplied, width unchanged
	logic [fpc_pkg::CNT_W-1:0] cnt_q;
	logic [fpc_pkg::CNT_W-1:0] cnt_d;

	wire [fpc_pkg::CNT_W-1:0] cnt_inc = cnt_q + 12'h001;
	wire [fpc_pkg::CNT_W-1:0] cnt_dec = cnt_q - 12'h001;

	// zero outranks a coincident step, which is then lost
	wire [fpc_pkg::CNT_W-1:0] cnt_step = sp.div_up ? cnt_inc : cnt_dec;

	always_comb
	begin
		cnt_d = cnt_q;
		if (zero_rise)
			cnt_d = fpc_pkg::CNT_RST;
		else if (sp.div_step)
			cnt_d = cnt_step;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_q <= fpc_pkg::CNT_RST;
		else
			cnt_q <= cnt_d;
	end

	// fed from the same next value, so the converter never lags the count
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			dac_code <= fpc_pkg::CNT_RST;
		else
			dac_code <= cnt_d;
	end

	//////////////////////////////////////////////////////////////////////////
	// status
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			range_active <= fpc_pkg::RANGE_RST;
		else
			range_active <= range_q;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			range_applied <= 1'b0;
		else
			range_applied <= applied_q;
	end

	// fixed per build; reported so system control can offer the right ranges
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			hires_variant <= 1'b0;
		else
			hires_variant <= HIRES;
	end
endmodule
`default_nettype wire

/* File: fpc_pkg.sv */
// shared constants of the fringe position counter
package fpc_pkg;
	localparam int unsigned CNT_W            = 12;
	localparam logic [11:0] CNT_RST          = 12'h000;
	localparam int unsigned DIV_W            = 8;
	localparam logic [7:0]  DIV_DIRECT       = 8'h01;
	localparam logic [7:0]  DIV_EXT1         = 8'h04;
	localparam logic [7:0]  DIV_EXT2         = 8'h10;
	localparam logic [7:0]  DIV_EXT3         = 8'h40;
	localparam int unsigned RANGE_W          = 2;
	localparam logic [1:0]  RANGE_RST        = 2'h0;
	// increment sizes, in tenths of a nanometre
	localparam int unsigned INC_DIRECT_DNM   = 3164;
	localparam int unsigned INC_HIRES_LO_DNM = 20;

	typedef enum logic [1:0]
	{
		FPC_RANGE_DIRECT,
		FPC_RANGE_EXT1,
		FPC_RANGE_EXT2,
		FPC_RANGE_EXT3
	} fpc_range_t;
endpackage

/* File: fpc_step_if.sv */
// step path between counter core and prescaler
`timescale 1ns/1ps
`default_nettype none
interface fpc_step_if;
	logic                          raw_step;
	logic                          raw_up;
	logic                          clear;
	logic [fpc_pkg::DIV_W-1:0]     factor;
	logic                          div_step;
	logic                          div_up;

	modport core (output raw_step, output raw_up, output clear, output factor,
		input div_step, input div_up);
	modport div (input raw_step, input raw_up, input clear, input factor,
		output div_step, output div_up);
endinterface
`default_nettype wire

/* File: fpc_prescaler.sv */
// direction-aware integer step divider
`timescale 1ns/1ps
`default_nettype none
module fpc_prescaler
(
	// clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// step path
	fpc_step_if.div   sp
);
	localparam int unsigned W = fpc_pkg::DIV_W + 1;

	logic signed [W-1:0] res_q;
	logic signed [W-1:0] res_d;
	logic                step_d;
	logic                step_q;
	logic                up_q;

	// residue signed so back-and-forth jitter around a boundary cancels out
	wire signed [W-1:0] lim_pos  = $signed({1'b0, sp.factor}) - 9'sd1;
	wire signed [W-1:0] lim_neg  = -lim_pos;
	wire                hit_up   = sp.raw_up && (res_q >= lim_pos);
	wire                hit_dn   = !sp.raw_up && (res_q <= lim_neg);
	wire                hit      = sp.raw_step && (hit_up || hit_dn);

	always_comb
	begin
		res_d  = res_q;
		step_d = 1'b0;
		if (sp.clear)
			res_d = '0;
		else if (hit)
		begin
			res_d  = '0;
			step_d = 1'b1;
		end
		else if (sp.raw_step)
			res_d = sp.raw_up ? res_q + 9'sd1 : res_q - 9'sd1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			res_q  <= '0;
			step_q <= 1'b0;
			up_q   <= 1'b0;
		end
		else
		begin
			res_q  <= res_d;
			step_q <= step_d;
			up_q   <= sp.raw_up;
		end
	end

	assign sp.div_step = step_q;
	assign sp.div_up   = up_q;
endmodule
`default_nettype wire

/* File: fpc_checker_properties.sv */
// port assertions for the fringe position counter
`timescale 1ns/1ps
`default_nettype none
module fpc_checker
#(
	parameter bit HIRES = 1'b0
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// demodulator pins
	input  wire logic        step_pulse,
	input  wire logic        step_up,
	input  wire logic        zero_pulse,
	// system control
	input  wire logic [1:0]  range_sel,
	input  wire logic        range_load,
	input  wire logic [1:0]  range_active,
	input  wire logic        range_applied,
	input  wire logic        hires_variant,
	// converter
	input  wire logic [11:0] dac_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	a_zero_clears: assert property ($rose(zero_pulse) |-> ##3 dac_code == 12'h000)
		else $error("no clear after zero");
	a_step_sign: assert property ($changed(dac_code) && dac_code != 12'h000 |->
		dac_code - $past(dac_code) == ($past(step_up, 5) ? 12'h001 : 12'hFFF))
		else $error("bad step size or sign");
	a_step_cause: assert property ($changed(dac_code) && dac_code != 12'h000 |->
		$past(step_pulse, 5) && !$past(step_pulse, 6))
		else $error("change without step");
	a_range_load: assert property (range_load |-> ##2 range_applied)
		else $error("no range applied");
	a_range_value: assert property (range_load |->
		##2 range_active == $past(range_sel, 2))
		else $error("wrong range");
	a_applied_cause: assert property (range_applied |-> $past(range_load, 2))
		else $error("applied without load");
	a_range_hold: assert property (!$past(range_load, 2) |-> $stable(range_active))
		else $error("range moved");
	a_variant_flag: assert property ($past(arst_n) |-> hires_variant == HIRES)
		else $error("variant flag wrong");
endmodule
bind fpc_counter fpc_checker #(.HIRES(HIRES)) u_fpc_checker (.clk, .arst_n, .step_pulse,
	.step_up, .zero_pulse, .range_sel, .range_load, .range_active, .range_applied,
	.hires_variant, .dac_code);
`default_nettype wire

/* File: fpc_demod_model.sv */
// demodulator stand-in: one signed step pulse per fringe
`timescale 1ns/1ps
`default_nettype none
module fpc_demod_model
(
	// clock
	input  wire logic clk,
	// step pins
	output var  logic step_pulse,
	output var  logic step_up
);
	initial
	begin
		step_pulse = 1'b0;
		step_up = 1'b0;
	end
	// sign released after its hold shows the inverse, not a stale match
	task automatic fringe(input logic up);
		@(posedge clk);
		step_up <= up;
		repeat (3) @(posedge clk);
		step_pulse <= 1'b1;
		repeat (2) @(posedge clk);
		step_pulse <= 1'b0;
		repeat (3) @(posedge clk);
		step_up <= ~up;
	endtask
endmodule
`default_nettype wire

/* File: test_fringe_position_counter.sv */
// self-checking bench for the fringe position counter
`timescale 1ns/1ps
`default_nettype none
module test_fringe_position_counter;
	logic        clk = 1'b0, arst_n = 1'b0, zero_pulse = 1'b0, range_load = 1'b0;
	logic        step_pulse, step_up, range_applied, hires_variant;
	logic [1:0]  range_sel = 2'h0, range_active;
	logic [11:0] dac_code, expd = 12'h000, last = 12'h000;
	logic [11:0] exp_q[$];
	logic [15:0] lfsr = 16'hF45B;
	int          failures = 0, n_compared = 0, res = 0, div = 1;
	always #25 clk = ~clk;
	fpc_counter #(.HIRES(1'b1)) u_fpc_counter (.clk, .arst_n, .step_pulse, .step_up,
		.zero_pulse, .range_sel, .range_load, .range_active, .range_applied,
		.hires_variant, .dac_code);
	fpc_demod_model u_fpc_demod_model (.clk, .step_pulse, .step_up);
	////////////////////////////////////////
	task automatic conclude();
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic fail(input string m);
		failures++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// signed residue: n same-way steps move the count by one
	task automatic step(input logic up);
		res += up ? 1 : -1;
		if (res == div || res == -div)
		begin
			expd = expd + (up ? 12'h001 : 12'hFFF);
			exp_q.push_back(expd);
			res = 0;
		end
		u_fpc_demod_model.fringe(up);
	endtask
	task automatic zero();
		@(posedge clk);
		zero_pulse <= 1'b1;
		repeat (2) @(posedge clk);
		zero_pulse <= 1'b0;
		if (expd != 12'h000) exp_q.push_back(12'h000);
		expd = 12'h000;
		res = 0;
		repeat (4) @(posedge clk);
	endtask
	task automatic load(input logic [1:0] r);
		@(posedge clk);
		range_sel <= r;
		range_load <= 1'b1;
		@(posedge clk);
		range_load <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		n_compared += 2;
		if (range_applied !== 1'b1) fail("applied");
		if (range_active !== r) fail("range");
		@(negedge clk);
		n_compared++;
		if (range_applied !== 1'b0) fail("applied held");
	endtask
	always @(negedge clk)
		if (arst_n && dac_code !== last)
		begin
			last = dac_code;
			n_compared++;
			if (exp_q.size() == 0 || exp_q.pop_front() !== dac_code) fail("dac");
		end
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		conclude();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		n_compared++;
		if (hires_variant !== 1'b1) fail("variant");
		step(1'b0);
		step(1'b1);
		for (int i = 0; i < 24; i++)
		begin
			lfsr = lfsr_next(lfsr);
			step(lfsr[0]);
		end
		zero();
		for (int r = 1; r < 4; r++)
		begin
			div = r == 1 ? fpc_pkg::DIV_EXT1 : r == 2 ? fpc_pkg::DIV_EXT2 : fpc_pkg::DIV_EXT3;
			load(r[1:0]);
			// mostly up so even the largest divider moves the count
			for (int i = 0; i < 3 * div; i++)
			begin
				lfsr = lfsr_next(lfsr);
				step(lfsr[0] | lfsr[1]);
			end
			zero();
		end
		load(2'h0);
		div = 1;
		step(1'b1);
		repeat (8) @(posedge clk);
		if (exp_q.size() != 0) fail("missing update");
		conclude();
	end
endmodule
`default_nettype wire
